// file: test_temp_sensor_i2c_slave_port.sv
`timescale 1ns/1ps
module test_temp_sensor_i2c_slave_port;
   import tsp_pkg::*;
   localparam int TOUT = 400;
   localparam logic [6:0] DEV = {TSP_ADDR_PREFIX, 3'b101};
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hv = 1'b0;
   logic alert_req = 1'b0;
   logic [15:0] rd_data = 16'h0000;
   logic scl, pull, sda_out, sda_oe, alert_out, alert_oe, swp_enable, bus_busy, reg_wr_stb;
   logic [7:0] reg_pointer;
   logic [15:0] reg_wr_data, last_wr;
   wire logic sda_bus = (sda_oe ? sda_out : 1'b1) & !pull;
   int n_fail, compares, n_stb, cyc;
   always #12.5 core_clk = ~core_clk;
   initial begin
      #3.3;
      forever #6 link_clk = ~link_clk;
   end
   always @(posedge core_clk) rd_data <= {8'hc3, reg_pointer ^ 8'h5a};
   always @(posedge core_clk) begin
      if (reg_wr_stb === 1'b1) begin
         n_stb <= n_stb + 1;
         last_wr <= reg_wr_data;
      end
   end
   tsp_i2c_slave_port #(.TOUT_CYCLES(TOUT)) u_tsp_i2c_slave_port (
      .core_clk(core_clk), .reset_n(reset_n), .scl_clk(scl), .sda_in(sda_bus),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit2(1'b1), .addr_strap_bit1(1'b0),
      .addr_strap_bit0_hv_detect(1'b1), .high_voltage_level(hv), .alert_request(alert_req),
      .alert_out(alert_out), .alert_oe(alert_oe), .swp_enable(swp_enable),
      .bus_busy(bus_busy), .reg_pointer(reg_pointer), .reg_rd_data(rd_data),
      .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb));
   tsp_host u_tsp_host (.link_clk(link_clk), .sda_bus(sda_bus), .scl_drv(scl), .sda_pull(pull));
   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [7:0] d, input logic exp);
      logic [7:0] q;
      logic a;
      u_tsp_host.xfer_byte(d, 1'b1, q, a);
      check(16'(a), 16'(exp));
   endtask
   task automatic recv(input logic ack_in, output logic [7:0] q);
      logic a;
      u_tsp_host.xfer_byte(8'hff, ack_in, q, a);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_side();
      for (int v = 1; v >= 0; v--) begin
         @(posedge core_clk);
         alert_req <= v[0];
         hv <= v[0];
         repeat (10) @(posedge core_clk);
         @(negedge core_clk);
         check(16'({alert_oe, swp_enable, alert_out}), 16'({v[0], v[0], 1'b0}));
      end
      $display("side test done");
   endtask
   task automatic t_write();
      int s0;
      s0 = n_stb;
      u_tsp_host.start_cond();
      send({DEV, 1'b0}, 1'b0);
      send(8'h05, 1'b0);
      send(8'h12, 1'b0);
      send(8'h34, 1'b0);
      u_tsp_host.stop_cond();
      check(16'(reg_pointer), 16'h0005);
      check(last_wr, 16'h1234);
      check(16'(n_stb - s0), 16'h0001);
      check(16'(bus_busy), 16'h0000);
      $display("write test done");
   endtask
   task automatic t_read(input logic [7:0] ptr);
      logic [7:0] hi, lo, hi2, tail;
      u_tsp_host.start_cond();
      send({DEV, 1'b1}, 1'b0);
      recv(1'b0, hi);
      recv(1'b0, lo);
      recv(1'b1, hi2);
      recv(1'b1, tail);
      u_tsp_host.stop_cond();
      check({hi, lo}, {8'hc3, ptr ^ 8'h5a});
      check({hi2, tail}, 16'hc3ff);
      $display("read test done");
   endtask
   task automatic t_mismatch();
      logic [6:0] bad [3] = '{7'h2d, 7'h19, 7'h1f};
      foreach (bad[i]) begin
         u_tsp_host.start_cond();
         send({bad[i], 1'b0}, 1'b1);
         send(8'h00, 1'b1);
         u_tsp_host.stop_cond();
      end
      check(16'(reg_pointer), 16'h0005);
      $display("mismatch test done");
   endtask
   task automatic t_abort();
      logic [7:0] q;
      logic a;
      int s0;
      s0 = n_stb;
      u_tsp_host.start_cond();
      send({DEV, 1'b0}, 1'b0);
      send(8'h07, 1'b0);
      for (int i = 0; i < 4; i++) u_tsp_host.xfer_bit(1'b0, a);
      u_tsp_host.stop_cond();
      u_tsp_host.start_cond();
      send({DEV, 1'b0}, 1'b0);
      for (int i = 0; i < 3; i++) u_tsp_host.xfer_bit(1'b1, a);
      u_tsp_host.start_cond();
      send({DEV, 1'b1}, 1'b0);
      recv(1'b1, q);
      u_tsp_host.stop_cond();
      check(16'(n_stb - s0), 16'h0000);
      check({reg_pointer, q}, 16'h07c3);
      $display("abort test done");
   endtask
   task automatic t_timeout();
      logic [7:0] q;
      u_tsp_host.start_cond();
      send({DEV, 1'b0}, 1'b0);
      check(16'(bus_busy), 16'h0001);
      // The clock is parked low well past the shortened timeout.
      u_tsp_host.wait_t(TOUT * 25 / 12 + 100);
      check(16'(bus_busy), 16'h0000);
      u_tsp_host.start_cond();
      send({DEV, 1'b1}, 1'b0);
      recv(1'b1, q);
      u_tsp_host.stop_cond();
      check(16'(q), 16'h00c3);
      $display("timeout test done");
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         $display("Error at %0t: run exceeded its cycle limit", $time);
         give_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      t_side();
      t_write();
      t_read(8'h05);
      t_mismatch();
      t_read(8'h05);
      t_abort();
      t_timeout();
      give_verdict();
   end
endmodule

// file: tsp_bus_monitor.sv
`timescale 1ns/1ps
module tsp_bus_monitor #(
   parameter int TOUT_CYCLES = tsp_pkg::TSP_TOUT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_s,
   input wire logic sda_s,
   output logic start_pulse,
   output logic stop_pulse,
   output logic timeout_pulse,
   output logic busy
);
   import tsp_pkg::*;

   logic scl_d_reg;
   logic sda_d_reg;
   logic [TSP_TOUT_W-1:0] stall_cnt_reg;
   logic start_det;
   logic stop_det;
   logic scl_moved;
   logic tout_hit;

   // ****************************************************************
   // Conditions on the bus.
   // ****************************************************************
   assign start_det = scl_d_reg & scl_s & sda_d_reg & ~sda_s; // R1
   assign stop_det = scl_d_reg & scl_s & ~sda_d_reg & sda_s; // R1
   assign scl_moved = scl_s ^ scl_d_reg;
   assign tout_hit = busy & ~scl_moved
      & (stall_cnt_reg == TSP_TOUT_W'(TOUT_CYCLES - 1)); // R19

   // History starts at the idle level so a reset never fakes a condition.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // ****************************************************************
   // Busy level and stall timer.
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (start_det) begin
         busy <= 1'b1; // R16
      end else if (stop_det || tout_hit) begin
         busy <= 1'b0; // R16
      end
   end

   // Only a stalled clock inside a frame counts; an idle bus never times out.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stall_cnt_reg <= '0;
      end else if (!busy || scl_moved || tout_hit) begin
         stall_cnt_reg <= '0;
      end else begin
         stall_cnt_reg <= stall_cnt_reg + 1'b1; // R19
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_pulse <= 1'b0;
         stop_pulse <= 1'b0;
         timeout_pulse <= 1'b0;
      end else begin
         start_pulse <= start_det;
         stop_pulse <= stop_det;
         timeout_pulse <= tout_hit;
      end
   end

endmodule

// file: tsp_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus master model.
// ****************************************************************
module tsp_host #(
   parameter int PH = 8
) (
   input wire logic link_clk,
   input wire logic sda_bus,
   output logic scl_drv,
   output logic sda_pull
);
   initial begin
      scl_drv = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic wait_t(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // Works from idle and as a repeated start from a low clock.
   task automatic start_cond();
      sda_pull <= 1'b0;
      wait_t(PH);
      scl_drv <= 1'b1;
      wait_t(2 * PH);
      sda_pull <= 1'b1;
      wait_t(2 * PH);
      scl_drv <= 1'b0;
      wait_t(PH);
   endtask
   task automatic stop_cond();
      sda_pull <= 1'b1;
      wait_t(PH);
      scl_drv <= 1'b1;
      wait_t(2 * PH);
      sda_pull <= 1'b0;
      wait_t(4 * PH);
   endtask
   // High phase is long so the core sampler sees every level.
   task automatic xfer_bit(input logic b, output logic r);
      sda_pull <= !b;
      wait_t(PH);
      scl_drv <= 1'b1;
      wait_t(PH);
      r = sda_bus;
      wait_t(PH);
      scl_drv <= 1'b0;
      wait_t(1);
   endtask
   task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                            output logic ack);
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
      xfer_bit(ack_in, ack);
   endtask
endmodule

// file: tsp_i2c_slave_port.sv
`timescale 1ns/1ps
// Function
// R1 - Start and Stop found while clock high
// R2 - Master frames every access with Start, Stop
// R3 - Address plus direction bit, each byte acknowledged
// R4 - Address is 0011 plus three strap levels
// R5 - Acknowledge only matching address, else release
// R6 - Direction bit one reads, zero writes
// R7 - Start or Stop mid-frame aborts, releases data
// R8 - Data changes only while clock low
// R9 - No pointer increment, one register per access
// R10 - Pointer kept; reads use last pointer
// R11 - Master gives ninth clock for acknowledge
// R12 - Acknowledge held low across whole ninth clock
// R13 - Master refusal ends read, data released
// R14 - Master waits bus-free time after Stop
// R15 - Slave only, never drives clock or conditions
// R16 - Idle both high, busy Start to Stop
// R17 - Open-drain alert asserts on temperature excursion
// R18 - Strap bit zero high voltage enables protect
// R19 - Stalled clock beyond timeout resets interface
// R20 - First written byte is register pointer
// R21 - Sample on rising clock, most significant first
module tsp_i2c_slave_port #(
   parameter int TOUT_CYCLES = tsp_pkg::TSP_TOUT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic scl_clk,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_bit2,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit0_hv_detect,
   input wire logic high_voltage_level,
   input wire logic alert_request,
   output logic alert_out,
   output logic alert_oe,
   output logic swp_enable,
   output logic bus_busy,
   output logic [7:0] reg_pointer,
   input wire logic [15:0] reg_rd_data,
   output logic [15:0] reg_wr_data,
   output logic reg_wr_stb
);
   import tsp_pkg::*;

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_sync_n;
   logic frame_run_reg;
   logic [1:0] pins_s;
   logic hv_s;
   logic start_pulse;
   logic stop_pulse;
   logic timeout_pulse;
   logic busy;
   logic [2:0] strap_s;
   logic [2:0] ack_tog_s;
   logic [1:0] tog_s;
   logic ptr_tog_d_reg;
   logic wr_tog_d_reg;
   logic [15:0] rd_hold_reg;
   logic [7:0] reg_pointer_reg;
   logic [15:0] reg_wr_data_reg;
   logic reg_wr_stb_reg;
   logic alert_oe_reg;
   logic swp_enable_reg;

   tsp_state_e state_reg;
   tsp_state_e state_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_shift_reg;
   logic [7:0] rx_byte;
   logic [7:0] tx_shift_reg;
   logic drive_low_reg;
   logic drive_low_next;
   logic sda_oe_reg;
   logic [7:0] ptr_link_reg;
   logic [7:0] wr_hi_reg;
   logic [15:0] wdata_link_reg;
   logic ptr_tog_reg;
   logic wr_tog_reg;
   logic last_bit;
   logic ack_bit;
   logic addr_hit;

   function automatic logic is_read_state(input tsp_state_e st);
      is_read_state = (st == TSP_ST_RD_HI) || (st == TSP_ST_RD_LO);
   endfunction

   // ****************************************************************
   // Reset release.
   // ****************************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // Core-side pin sampling and bus watch.
   // ****************************************************************
   tsp_sync2 #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(core_clk),
      .rst_n(rst_sync_n),
      .async_in({scl_clk, sda_in}),
      .sync_out(pins_s)
   );

   tsp_sync2 #(
      .WIDTH(1)
   ) u_hv_sync (
      .clk(core_clk),
      .rst_n(rst_sync_n),
      .async_in(high_voltage_level),
      .sync_out(hv_s)
   );

   tsp_bus_monitor #(
      .TOUT_CYCLES(TOUT_CYCLES)
   ) u_monitor (
      .clk(core_clk),
      .rst_n(rst_sync_n),
      .scl_s(pins_s[1]),
      .sda_s(pins_s[0]),
      .start_pulse(start_pulse),
      .stop_pulse(stop_pulse),
      .timeout_pulse(timeout_pulse),
      .busy(busy)
   );

   // Any condition or a timeout clears the link side at once, without
   // waiting for a clock edge that a stalled master may never give.
   // SCL is steady for microseconds around every such event, so the
   // asynchronous release cannot race a link edge.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         frame_run_reg <= 1'b0;
      end else begin
         frame_run_reg <= ~(start_pulse | stop_pulse | timeout_pulse); // R7 R19
      end
   end

   // ****************************************************************
   // Link side: straps, counter, shifters.
   // ****************************************************************
   // Straps are static after power-up, so eight address clocks are
   // ample for the two sampling stages to settle.
   tsp_sync2 #(
      .WIDTH(3)
   ) u_strap_sync (
      .clk(scl_clk),
      .rst_n(rst_sync_n),
      .async_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0_hv_detect}),
      .sync_out(strap_s)
   );

   assign last_bit = (bit_cnt_reg == TSP_LAST_BIT);
   assign ack_bit = (bit_cnt_reg == TSP_ACK_BIT);
   assign rx_byte = {rx_shift_reg[6:0], sda_in}; // R21
   assign addr_hit = (rx_byte[7:1] == {TSP_ADDR_PREFIX, strap_s}); // R4 R5

   always_ff @(posedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         bit_cnt_reg <= TSP_BIT_RESET;
      end else if (ack_bit) begin
         bit_cnt_reg <= TSP_BIT_RESET; // R11
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         rx_shift_reg <= TSP_BYTE_RESET;
      end else if (!ack_bit) begin
         rx_shift_reg <= rx_byte; // R21
      end
   end

   // The read word is loaded on the ninth clock; a second pair of bytes
   // repeats the same register because the pointer never advances.
   always_ff @(posedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         tx_shift_reg <= TSP_BYTE_RESET;
      end else if (ack_bit && state_reg == TSP_ST_RD_HI) begin
         tx_shift_reg <= {rd_hold_reg[14:8], 1'b0}; // R9
      end else if (ack_bit && state_reg == TSP_ST_RD_LO) begin
         tx_shift_reg <= {rd_hold_reg[6:0], 1'b0}; // R9
      end else if (!ack_bit) begin
         tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // R21
      end
   end

   // ****************************************************************
   // Link side: transfer sequence.
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      drive_low_next = 1'b0;
      if (last_bit) begin
         case (state_reg)
            TSP_ST_ADDR: begin
               if (addr_hit) begin
                  drive_low_next = 1'b1; // R3 R5
                  if (rx_byte[TSP_DIR_BIT]) begin
                     state_next = TSP_ST_RD_HI; // R6
                  end else begin
                     state_next = TSP_ST_PTR; // R6 R20
                  end
               end else begin
                  state_next = TSP_ST_IGNORE; // R5
               end
            end
            TSP_ST_PTR: begin
               drive_low_next = 1'b1; // R3
               state_next = TSP_ST_WR_HI;
            end
            TSP_ST_WR_HI: begin
               drive_low_next = 1'b1; // R3
               state_next = TSP_ST_WR_LO;
            end
            TSP_ST_WR_LO: begin
               drive_low_next = 1'b1; // R3
               state_next = TSP_ST_IGNORE;
            end
            TSP_ST_RD_HI: begin
               state_next = TSP_ST_RD_LO;
            end
            TSP_ST_RD_LO: begin
               state_next = TSP_ST_RD_HI; // R9
            end
            TSP_ST_IGNORE: begin
               state_next = TSP_ST_IGNORE;
            end
            default: begin
               state_next = TSP_ST_IGNORE;
            end
         endcase
      end else if (ack_bit) begin
         if (is_read_state(state_reg) && sda_in) begin
            state_next = TSP_ST_IGNORE; // R13
         end else if (state_reg == TSP_ST_RD_HI) begin
            drive_low_next = ~rd_hold_reg[15]; // R21
         end else if (state_reg == TSP_ST_RD_LO) begin
            drive_low_next = ~rd_hold_reg[7]; // R21
         end
      end else if (is_read_state(state_reg)) begin
         drive_low_next = ~tx_shift_reg[7]; // R21
      end
   end

   // A master that skips the Start would be decoded as an address byte;
   // the bus protocol forbids it, so no extra arming flag is kept.
   always_ff @(posedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         state_reg <= TSP_ST_ADDR; // R2
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         drive_low_reg <= 1'b0;
      end else begin
         drive_low_reg <= drive_low_next;
      end
   end

   // Apart from the clear when frame_run_reg drops, the pin only moves on a falling clock,
   // so it stays put while SCL is high and the acknowledge spans the whole ninth clock.
   always_ff @(negedge scl_clk or negedge frame_run_reg) begin
      if (!frame_run_reg) begin
         sda_oe_reg <= 1'b0; // R7
      end else begin
         sda_oe_reg <= drive_low_reg; // R8 R12
      end
   end

   // ****************************************************************
   // Link side: pointer and write word, held across frames.
   // ****************************************************************
   always_ff @(posedge scl_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ptr_link_reg <= TSP_PTR_RESET;
         ptr_tog_reg <= 1'b0;
      end else if (last_bit && state_reg == TSP_ST_PTR) begin
         ptr_link_reg <= rx_byte; // R20
         ptr_tog_reg <= ~ptr_tog_reg;
      end
   end

   always_ff @(posedge scl_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_hi_reg <= TSP_BYTE_RESET;
         wdata_link_reg <= TSP_WORD_RESET;
         wr_tog_reg <= 1'b0;
      end else if (last_bit && state_reg == TSP_ST_WR_HI) begin
         wr_hi_reg <= rx_byte;
      end else if (last_bit && state_reg == TSP_ST_WR_LO) begin
         wdata_link_reg <= {wr_hi_reg, rx_byte};
         wr_tog_reg <= ~wr_tog_reg;
      end
   end

   // ****************************************************************
   // Crossing back to the core clock.
   // ****************************************************************
   tsp_sync2 #(
      .WIDTH(2)
   ) u_tog_sync (
      .clk(core_clk),
      .rst_n(rst_sync_n),
      .async_in({ptr_tog_reg, wr_tog_reg}),
      .sync_out(tog_s)
   );

   assign ack_tog_s = {tog_s[1] ^ ptr_tog_d_reg, tog_s[0] ^ wr_tog_d_reg, 1'b0};

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ptr_tog_d_reg <= 1'b0;
         wr_tog_d_reg <= 1'b0;
      end else begin
         ptr_tog_d_reg <= tog_s[1];
         wr_tog_d_reg <= tog_s[0];
      end
   end

   // The pointer survives every abort and Stop; only a new pointer byte
   // replaces it.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_pointer_reg <= TSP_PTR_RESET;
      end else if (ack_tog_s[2]) begin
         reg_pointer_reg <= ptr_link_reg; // R10
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_wr_data_reg <= TSP_WORD_RESET;
         reg_wr_stb_reg <= 1'b0;
      end else begin
         reg_wr_stb_reg <= ack_tog_s[1]; // R9
         if (ack_tog_s[1]) begin
            reg_wr_data_reg <= wdata_link_reg;
         end
      end
   end

   // The read word is frozen from each Start so the link side can pick it
   // up without a handshake; the pointer has long settled by then.
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_hold_reg <= TSP_WORD_RESET;
      end else if (!busy || start_pulse) begin
         rd_hold_reg <= reg_rd_data; // R10
      end
   end

   // ****************************************************************
   // Side outputs.
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         alert_oe_reg <= 1'b0;
         swp_enable_reg <= 1'b0;
      end else begin
         alert_oe_reg <= alert_request; // R17
         swp_enable_reg <= hv_s; // R18
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg; // R15
   assign alert_out = 1'b0; // R17
   assign alert_oe = alert_oe_reg;
   assign swp_enable = swp_enable_reg;
   assign bus_busy = busy; // R16
   assign reg_pointer = reg_pointer_reg;
   assign reg_wr_data = reg_wr_data_reg;
   assign reg_wr_stb = reg_wr_stb_reg;

endmodule

// file: tsp_pkg.sv
package tsp_pkg;

   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int TSP_CORE_CLK_HZ = 40_000_000;
   localparam int TSP_TOUT_MS = 20;
   localparam int TSP_TOUT_CYCLES = TSP_TOUT_MS * (TSP_CORE_CLK_HZ / 1000);
   localparam int TSP_TOUT_W = 20;

   // ****************************************************************
   // Address byte and bit positions.
   // ****************************************************************
   localparam logic [3:0] TSP_ADDR_PREFIX = 4'h3;
   localparam logic [3:0] TSP_LAST_BIT = 4'h7;
   localparam logic [3:0] TSP_ACK_BIT = 4'h8;
   localparam logic [3:0] TSP_BIT_RESET = 4'h0;
   localparam int TSP_DIR_BIT = 0;

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [7:0] TSP_PTR_RESET = 8'h00;
   localparam logic [7:0] TSP_BYTE_RESET = 8'h00;
   localparam logic [15:0] TSP_WORD_RESET = 16'h0000;

   typedef enum logic [2:0] {
      TSP_ST_ADDR = 3'b000,
      TSP_ST_PTR = 3'b001,
      TSP_ST_WR_HI = 3'b010,
      TSP_ST_WR_LO = 3'b011,
      TSP_ST_RD_HI = 3'b100,
      TSP_ST_RD_LO = 3'b101,
      TSP_ST_IGNORE = 3'b110
   } tsp_state_e;

endpackage

// file: tsp_port_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker.
// ****************************************************************
module tsp_port_sva #(
   parameter int TOUT_CYCLES = 400
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic high_voltage_level,
   input wire logic alert_request,
   input wire logic alert_out,
   input wire logic alert_oe,
   input wire logic swp_enable,
   input wire logic bus_busy,
   input wire logic [7:0] reg_pointer,
   input wire logic [15:0] reg_wr_data,
   input wire logic reg_wr_stb
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   logic scl_q;
   int stall_cnt;
   // The raw pin leads the synced copy by two cycles, so the bound carries slack.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         stall_cnt <= 0;
      end else begin
         scl_q <= scl_clk;
         stall_cnt <= (bus_busy && scl_q == scl_clk) ? stall_cnt + 1 : 0;
      end
   end
   sequence s_start;
      scl_clk && $past(scl_clk) && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_clk && $past(scl_clk) && $rose(sda_in);
   endsequence
   AST_START_BUSY: assert property (s_start |-> ##[1:8] bus_busy)
      else $error("busy missing after start");
   AST_STOP_IDLE: assert property (s_stop |-> ##[1:8] !bus_busy)
      else $error("busy stuck after stop");
   AST_STALL_LIMIT: assert property (stall_cnt <= TOUT_CYCLES + 16)
      else $error("stalled clock not timed out");
   AST_IDLE_RELEASE: assert property (!bus_busy [*6] |-> !sda_oe)
      else $error("data driven while idle");
   AST_OE_RISE_LOW: assert property ($rose(sda_oe) |-> !scl_clk)
      else $error("data pulled while clock high");
   AST_OE_HOLD_HIGH: assert property (scl_clk && $past(scl_clk) && $past(sda_oe) && bus_busy |-> sda_oe)
      else $error("data released while clock high");
   AST_OPEN_DRAIN: assert property (!sda_out && !alert_out)
      else $error("open drain pin driven high");
   AST_ALERT_FOLLOW: assert property (alert_oe == $past(alert_request))
      else $error("alert not following request");
   AST_SWP_SET: assert property (high_voltage_level [*8] |-> swp_enable)
      else $error("protect not enabled");
   AST_SWP_CLEAR: assert property (!high_voltage_level [*8] |-> !swp_enable)
      else $error("protect not cleared");
   AST_WR_ONE_PULSE: assert property (reg_wr_stb |-> bus_busy ##1 !reg_wr_stb)
      else $error("write strobe not single");
   AST_WR_DATA_ON_STB: assert property ($changed(reg_wr_data) |-> reg_wr_stb)
      else $error("write data moved without strobe");
   AST_PTR_IN_FRAME: assert property ($changed(reg_pointer) |-> bus_busy)
      else $error("pointer moved outside frame");
endmodule

bind tsp_i2c_slave_port tsp_port_sva #(.TOUT_CYCLES(TOUT_CYCLES)) u_tsp_port_sva (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .scl_clk(scl_clk),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .high_voltage_level(high_voltage_level),
   .alert_request(alert_request),
   .alert_out(alert_out),
   .alert_oe(alert_oe),
   .swp_enable(swp_enable),
   .bus_busy(bus_busy),
   .reg_pointer(reg_pointer),
   .reg_wr_data(reg_wr_data),
   .reg_wr_stb(reg_wr_stb)
);

// file: tsp_sync2.sv
`timescale 1ns/1ps
module tsp_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule
